//--- dv/instr_decoder_bench.sv
/*
 * Self-checking bench for instr_decoder: a table of words, each run from a
 * filled program memory, then skip, zero, hold, bus and prescaler cases.
 * Assumes the package, header and prog_mem model are compiled first.
 */
`timescale 1ns/1ps
`include "instr_decoder_defines.svh"

module instr_decoder_bench
    import instr_decoder_pkg::*;
;
    typedef struct packed {logic [13:0] w; op_e op; logic [4:0] f;} row_s; // f: c dc z two pin

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce  = 1'b1;
    logic [7:0]  alu = 8'h00;
    logic [7:0]  upl = 8'h10;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [13:0] fw;
    decode_s     dec;
    logic [1:0]  phase;
    logic        cstart, pc_load, zero_flag, pin, presc, ack;
    logic [12:0] pc_target;
    int          n_mismatch = 0, checks = 0, cycles = 0, n;
    row_s        r;
    logic [7:0]  rd_adr [4] = '{`REG_CTRL, `REG_TIMER_ADDR, `REG_PORT_RANGE, 8'h20};
    logic [31:0] rd_exp [4] = '{`CTRL_RESET, {25'h0, `TIMER_ADDR_RESET},
                                {17'h0, `PORT_HI_RESET, 1'b0, `PORT_LO_RESET}, 32'h0};
    row_s        rows [$] = '{
        '{14'h07A5, OP_ADD_FILE, 5'b11100}, '{14'h027F, OP_SUB_FILE, 5'b11100},
        '{14'h0580, OP_AND_FILE, 5'b00100}, '{14'h0401, OP_IOR_FILE, 5'b00100},
        '{14'h06B3, OP_XOR_FILE, 5'b00100}, '{14'h0E90, OP_SWAP, 5'b00000},
        '{14'h0D10, OP_ROT_LEFT, 5'b10000}, '{14'h0C90, OP_ROT_RIGHT, 5'b10000},
        '{14'h0381, OP_DEC, 5'b00100}, '{14'h0A02, OP_INC, 5'b00100},
        '{14'h0B83, OP_DEC_SKIPZ, 5'b00010}, '{14'h0F04, OP_INC_SKIPZ, 5'b00010},
        '{14'h0885, OP_MOVE_FILE, 5'b00101}, '{14'h0906, OP_COMP, 5'b00100},
        '{14'h0187, OP_CLR_FILE, 5'b00100}, '{14'h0100, OP_CLR_ACC, 5'b00100},
        '{14'h017F, OP_CLR_ACC, 5'b00100}, '{14'h00A0, OP_STORE_ACC, 5'b00000},
        '{14'h0000, OP_NOP, 5'b00000}, '{14'h0060, OP_NOP, 5'b00000},
        '{14'h0001, OP_NOP, 5'b00000}, '{14'h0065, OP_NOP, 5'b00000},
        '{14'h0064, OP_CLR_WATCHDOG, 5'b00000}, '{14'h0063, OP_STANDBY, 5'b00000},
        '{14'h0009, OP_RET_INT, 5'b00010}, '{14'h0008, OP_RET_SUB, 5'b00010},
        '{14'h1289, OP_BIT_CLR, 5'b00001}, '{14'h147F, OP_BIT_SET, 5'b00000},
        '{14'h1BA0, OP_SKIP_IF_CLR, 5'b00010}, '{14'h1D81, OP_SKIP_IF_SET, 5'b00000},
        '{14'h3F5A, OP_ADD_LIT, 5'b11100}, '{14'h3CA5, OP_SUB_LIT, 5'b11100},
        '{14'h390F, OP_AND_LIT, 5'b00100}, '{14'h38F0, OP_IOR_LIT, 5'b00100},
        '{14'h3AFF, OP_XOR_LIT, 5'b00100}, '{14'h3312, OP_LOAD_LIT, 5'b00000},
        '{14'h3734, OP_RET_LIT, 5'b00010}, '{14'h2123, OP_CALL, 5'b00010},
        '{14'h2C56, OP_JUMP, 5'b00010}};

    instr_decoder instr_decoder_i (.clk(clk), .rst(rst), .ce(ce), .fetch_word(fw),
        .alu_value(alu), .upper_pc_latch(upl), .dec(dec), .phase(phase),
        .cycle_start(cstart), .pc_load(pc_load), .pc_target(pc_target),
        .zero_flag(zero_flag), .use_pin_levels(pin), .prescaler_clear(presc),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
    prog_mem prog_mem_i (.clk(clk), .rst(rst), .ce(ce), .phase(phase), .pc_load(pc_load),
        .pc_target(pc_target), .fetch_word(fw));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic chk_op(input string nm, input op_e e, input op_e g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_op

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    // reset with memory full of one word; returns in phase 0 of its first decode
    task automatic run_word(input logic [13:0] w);
        for (int k = 0; k < 16; k++)
            prog_mem_i.rom[k] = w;
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(4);
    endtask : run_word

    // request held until ack is sampled high at a rising edge; data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // a hung handshake must still reach the verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        foreach (rows[i])
        begin
            r = rows[i];
            run_word(r.w);
            chk_op("op", r.op, dec.op);
            chk("phase", 2'h0, phase);
            chk("flags", r.f[4:2], {dec.upd_carry, dec.upd_digit_carry, dec.upd_zero});
            chk("pins", r.f[0], pin);
            chk("wdt", r.op == OP_CLR_WATCHDOG || r.op == OP_STANDBY, dec.upd_wdt_flags);
            if (r.w[13:12] == 2'b00)
                chk("dest", r.w[7], dec.dest_file);
            if (r.w[13] == 1'b0 && r.w[13:8] != 6'h00 && r.op != OP_CLR_ACC)
                chk("file", r.w[6:0], dec.file_addr);
            if (r.w[13:12] == 2'b01)
                chk("bit", r.w[9:7], dec.bit_idx);
            if (r.w[13:12] == 2'b11)
                chk("lit", r.w[7:0], dec.literal);
            step(4);
            chk("zero", r.f[2], zero_flag);
            chk("load", r.w[13:12] == 2'b10, pc_load);
            if (r.w[13:12] == 2'b10)
                chk("target", {upl[4:3], r.w[10:0]}, pc_target);
            chk_op("next", r.f[1] ? OP_NOP : r.op, dec.op);
            chk("presc", 1'b0, presc);
            $display("row %0d word %h done", i, r.w);
        end
        alu <= 8'h08;
        run_word(14'h1D81);
        step(4);
        chk_op("skipset", OP_NOP, dec.op);
        alu <= 8'h40;
        run_word(14'h0F04);
        step(4);
        chk_op("noskip", OP_INC_SKIPZ, dec.op);
        alu <= 8'h00;
        run_word(14'h0A02);
        step(4);
        chk("zero", 1'b1, zero_flag);
        alu <= 8'h40;
        step(4);
        chk("zero", 1'b0, zero_flag);
        ce <= 1'b0;
        step(3);
        chk("hold", 2'h0, phase);
        chk("start", 1'b0, cstart);
        ce <= 1'b1;
        $display("skip, zero and hold tests done");
        run_word(14'h0381);
        foreach (rd_adr[i])
        begin
            wb(1'b0, rd_adr[i], 32'h0, rdat);
            chk("reg", rd_exp[i], rdat);
        end
        wb(1'b1, `REG_CTRL, 32'h0000_0003, rdat);
        n = 0;
        repeat (8)
        begin
            step(1);
            if (presc === 1'b1)
                n++;
        end
        chk("presc", 2, n);
        wb(1'b0, `REG_LAST_WORD, 32'h0, rdat);
        chk("last", 32'h0000_0381, rdat);
        wb(1'b1, `REG_CTRL, 32'h0000_0000, rdat);
        step(8);
        chk_op("halt", OP_NOP, dec.op);
        wb(1'b0, `REG_STATUS, 32'h0, rdat);
        chk("status", 32'h0, rdat & 32'hFFFF_FFFC);
        $display("bus and prescaler tests done");
        complete_run();
    end
endmodule : instr_decoder_bench

//--- dv/prog_mem.sv
/*
 * Program memory model: sixteen words fetched in order, reloaded on a branch.
 * Assumes the decoder samples fetch_word at the edge that ends phase 3.
 */
`timescale 1ns/1ps

module prog_mem
    import instr_decoder_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [1:0]  phase,
    input  wire logic        pc_load,
    input  wire logic [12:0] pc_target,
    output logic      [13:0] fetch_word
);
    logic [13:0] rom [16];
    logic [3:0]  ptr;

    // only the low target bits matter in so small a memory
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ptr <= 4'h0;
        else if (ce && pc_load)
            ptr <= pc_target[3:0];
        else if (ce && phase == 2'h3)
            ptr <= ptr + 4'h1;
    end

    // word changes only at the end of phase 3, or of phase 0 on a load, so phase 3 sees it settled
    assign fetch_word = rom[ptr];
endmodule : prog_mem

//--- rtl/instr_decoder.sv
/*
 * Instruction decoder and execution timing for a 14-bit single-accumulator
 * core, with a classic Wishbone slave for its control and status.
 * Assumes program memory presents the next word on fetch_word, stable in the
 * last phase of each instruction cycle, and that the datapath returns the
 * operand or result of the executing instruction on alu_value by then.
 */
`timescale 1ns/1ps
`include "instr_decoder_defines.svh"

module instr_decoder
    import instr_decoder_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [13:0] fetch_word,
    input  wire logic [7:0]  alu_value,
    input  wire logic [7:0]  upper_pc_latch,
    output decode_s          dec,
    output logic [1:0]       phase,
    output logic             cycle_start,
    output logic             pc_load,
    output logic [12:0]      pc_target,
    output logic             zero_flag,
    output logic             use_pin_levels,
    output logic             prescaler_clear,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    localparam int PHASE_LAST = `PHASES_PER_CYCLE - 1;
    logic [31:0] ctrl;
    logic [6:0]  timer_addr;
    logic [6:0]  port_lo;
    logic [6:0]  port_hi;
    logic [13:0] last_word;
    logic        cycle_end;
    logic        skip_true;
    logic        redirect;
    logic        wr_hit;
    decode_s     next_dec;

    // decode one word; unknown encodings fall out as a plain no-op
    function automatic decode_s decode(input logic [13:0] w);
        decode_s r;
        r = '0;
        r.op = OP_NOP;
        r.file_addr = w[`FILE_MSB:0];
        r.dest_file = w[`DEST_BIT];
        r.bit_idx = w[`BIT_IDX_LSB+2:`BIT_IDX_LSB];
        r.literal = w[7:0];
        r.target = w[10:0];
        case (w[13:12])
            2'h0:
            begin
                case (w[11:8])
                    4'h7: r.op = OP_ADD_FILE;
                    4'h2: r.op = OP_SUB_FILE;
                    4'h5: r.op = OP_AND_FILE;
                    4'h4: r.op = OP_IOR_FILE;
                    4'h6: r.op = OP_XOR_FILE;
                    4'hD: r.op = OP_ROT_LEFT;
                    4'hC: r.op = OP_ROT_RIGHT;
                    4'hE: r.op = OP_SWAP;
                    4'h3: r.op = OP_DEC;
                    4'hA: r.op = OP_INC;
                    4'hB: r.op = OP_DEC_SKIPZ;
                    4'hF: r.op = OP_INC_SKIPZ;
                    4'h8: r.op = OP_MOVE_FILE;
                    4'h9: r.op = OP_COMP;
                    4'h1: r.op = w[7] ? OP_CLR_FILE : OP_CLR_ACC;
                    4'h0:
                    begin
                        // store first, then fixed words, don't-care bits of no-op masked
                        if (w[7])
                            r.op = OP_STORE_ACC;
                        else if (w[6:0] == 7'h64)
                            r.op = OP_CLR_WATCHDOG;
                        else if (w[6:0] == 7'h63)
                            r.op = OP_STANDBY;
                        else if (w[6:0] == 7'h09)
                            r.op = OP_RET_INT;
                        else if (w[6:0] == 7'h08)
                            r.op = OP_RET_SUB;
                        else
                            r.op = OP_NOP;
                    end
                    default: r.op = OP_NOP;
                endcase
            end
            2'h1:
            begin
                case (w[11:10])
                    2'h0: r.op = OP_BIT_CLR;
                    2'h1: r.op = OP_BIT_SET;
                    2'h2: r.op = OP_SKIP_IF_CLR;
                    default: r.op = OP_SKIP_IF_SET;
                endcase
            end
            2'h2: r.op = w[11] ? OP_JUMP : OP_CALL;
            default:
            begin
                casez (w[11:8])
                    4'b111?: r.op = OP_ADD_LIT;
                    4'b110?: r.op = OP_SUB_LIT;
                    4'h9: r.op = OP_AND_LIT;
                    4'h8: r.op = OP_IOR_LIT;
                    4'hA: r.op = OP_XOR_LIT;
                    4'b00??: r.op = OP_LOAD_LIT;
                    4'b01??: r.op = OP_RET_LIT;
                    default: r.op = OP_NOP;
                endcase
            end
        endcase
        // flag selection per operation
        case (r.op)
            OP_ADD_FILE, OP_SUB_FILE, OP_ADD_LIT, OP_SUB_LIT:
            begin
                r.upd_carry = 1'b1;
                r.upd_digit_carry = 1'b1;
                r.upd_zero = 1'b1;
            end
            OP_AND_FILE, OP_IOR_FILE, OP_XOR_FILE, OP_DEC, OP_INC, OP_MOVE_FILE,
            OP_COMP, OP_CLR_FILE, OP_CLR_ACC, OP_AND_LIT, OP_IOR_LIT, OP_XOR_LIT:
                r.upd_zero = 1'b1;
            OP_ROT_LEFT, OP_ROT_RIGHT:
                r.upd_carry = 1'b1;
            OP_CLR_WATCHDOG, OP_STANDBY:
                r.upd_wdt_flags = 1'b1;
            default: r.upd_zero = 1'b0;
        endcase
        // literal-format results and fixed ops never land in a file register
        case (r.op)
            OP_STORE_ACC, OP_CLR_FILE, OP_BIT_CLR, OP_BIT_SET:
            begin
                r.dest_file = 1'b1;
                r.writes_file = 1'b1;
            end
            OP_ADD_FILE, OP_SUB_FILE, OP_AND_FILE, OP_IOR_FILE, OP_XOR_FILE,
            OP_ROT_LEFT, OP_ROT_RIGHT, OP_SWAP, OP_DEC, OP_INC, OP_DEC_SKIPZ,
            OP_INC_SKIPZ, OP_MOVE_FILE, OP_COMP:
                r.writes_file = r.dest_file;
            default: r.dest_file = 1'b0;
        endcase
        r.changes_pc = (r.op == OP_CALL) || (r.op == OP_JUMP) || (r.op == OP_RET_LIT) ||
                       (r.op == OP_RET_INT) || (r.op == OP_RET_SUB);
        return r;
    endfunction : decode

    // four clock phases make one instruction cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            phase <= 2'h0;
        else if (ce)
            phase <= (phase == PHASE_LAST[1:0]) ? 2'h0 : phase + 2'h1;
    end

    assign cycle_start = ce && (phase == 2'h0);
    assign cycle_end   = ce && (phase == PHASE_LAST[1:0]);
    // skip condition from the operand or result the datapath returns
    always_comb
    begin
        case (dec.op)
            OP_DEC_SKIPZ, OP_INC_SKIPZ: skip_true = (alu_value == 8'h00);
            OP_SKIP_IF_CLR: skip_true = !alu_value[dec.bit_idx];
            OP_SKIP_IF_SET: skip_true = alu_value[dec.bit_idx];
            default: skip_true = 1'b0;
        endcase
    end

    assign redirect = dec.changes_pc || skip_true;
    // a halted core decodes everything as no-op so the datapath idles
    assign next_dec = (redirect || !ctrl[`CTRL_RUN_BIT]) ? decode(14'h0000)
                                                         : decode(fetch_word);

    // decoded word is loaded at each cycle boundary; redirect flushes it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dec <= '0;                                                    // all-zero is the no-op
        else if (cycle_end)
            dec <= next_dec;
    end

    // word last fetched at a cycle end without redirect, even while halted, kept for software inspection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            last_word <= 14'h0000;
        else if (cycle_end && !redirect)
            last_word <= fetch_word;
    end

    // branch target with upper bits from the latch, one-cycle load pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pc_load   <= 1'b0;
            pc_target <= 13'h0000;
        end
        else if (ce)
        begin
            pc_load <= cycle_end && ((dec.op == OP_CALL) || (dec.op == OP_JUMP));
            if (cycle_end)
                pc_target <= {upper_pc_latch[`UPPER_PC_LO+1:`UPPER_PC_LO], dec.target};
        end
    end

    // zero flag follows the 8-bit result of every zero-updating op
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            zero_flag <= 1'b0;
        else if (cycle_end && dec.upd_zero)
            zero_flag <= (alu_value == 8'h00);
    end

    // self-modifying port access sources the pins, not the latch
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            use_pin_levels <= 1'b0;
        else if (cycle_end)
            use_pin_levels <= next_dec.writes_file && (next_dec.op != OP_STORE_ACC) &&
                              (next_dec.op != OP_CLR_FILE) &&
                              (next_dec.file_addr >= port_lo) &&
                              (next_dec.file_addr <= port_hi);
    end

    // timer-zero writes clear the prescaler only while it is assigned there
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prescaler_clear <= 1'b0;
        else if (ce)
            prescaler_clear <= cycle_end && dec.writes_file &&
                               (dec.file_addr == timer_addr) &&
                               ctrl[`CTRL_PRESC_T0_BIT];
    end

    // bus slave: ack a cycle after the strobe; writes land on the edge that sees ack
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else if (ce)
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    // writable registers; lane 0 carries their bits, lane 1 the port_hi field
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl       <= `CTRL_RESET;
            timer_addr <= `TIMER_ADDR_RESET;
            port_lo    <= `PORT_LO_RESET;
            port_hi    <= `PORT_HI_RESET;
        end
        else if (ce && wr_hit)
        begin
            case (wb_adr_i)
                `REG_CTRL:
                    if (wb_sel_i[0])
                        ctrl <= {30'h0, wb_dat_i[1:0]};
                `REG_TIMER_ADDR:
                    if (wb_sel_i[0])
                        timer_addr <= wb_dat_i[6:0];
                `REG_PORT_RANGE:
                begin
                    if (wb_sel_i[0])
                        port_lo <= wb_dat_i[6:0];
                    if (wb_sel_i[1])
                        port_hi <= wb_dat_i[14:8];
                end
                default: ctrl <= ctrl; // unmapped writes are ignored
            endcase
        end
    end

    // read data registered with the ack; unmapped offsets read zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wb_dat_o <= 32'h0000_0000;
        else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o)
        begin
            case (wb_adr_i)
                `REG_CTRL:       wb_dat_o <= ctrl;
                `REG_TIMER_ADDR: wb_dat_o <= {25'h0, timer_addr};
                `REG_PORT_RANGE: wb_dat_o <= {17'h0, port_hi, 1'b0, port_lo};
                `REG_STATUS:     wb_dat_o <= {16'h0, 2'h0, dec.op, 5'h0, zero_flag, phase};
                `REG_LAST_WORD:  wb_dat_o <= {18'h0, last_word};
                default:         wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // checks on the decoded controls and their timing
    phase_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (ce && phase == 2'h3) |=> (phase == 2'h0))
        else $error("phase did not wrap after four");
    flush_after_branch_a: assert property (@(posedge clk) disable iff (rst)
        (cycle_end && dec.changes_pc) |=> (dec.op == OP_NOP))
        else $error("branch did not flush next word");
    skip_flush_a: assert property (@(posedge clk) disable iff (rst)
        (cycle_end && skip_true) |=> (dec.op == OP_NOP && !dec.writes_file))
        else $error("true skip kept fetched word");
    call_target_a: assert property (@(posedge clk) disable iff (rst)
        (cycle_end && (dec.op == OP_JUMP || dec.op == OP_CALL)) |=>
        (pc_load && pc_target == {$past(upper_pc_latch[4:3]), $past(dec.target)}))
        else $error("branch target wrong");
    zero_track_a: assert property (@(posedge clk) disable iff (rst)
        (cycle_end && dec.upd_zero) |=> (zero_flag == ($past(alu_value) == 8'h00)))
        else $error("zero flag wrong");
    skip_no_flags_a: assert property (@(posedge clk) disable iff (rst)
        (dec.op == OP_INC_SKIPZ || dec.op == OP_DEC_SKIPZ) |->
        !(dec.upd_zero || dec.upd_carry))
        else $error("skip op updates flags");
    dest_select_a: assert property (@(posedge clk) disable iff (rst)
        (dec.op == OP_ADD_FILE) |-> (dec.writes_file == dec.dest_file))
        else $error("destination select ignored");
    prescaler_clear_a: assert property (@(posedge clk) disable iff (rst)
        prescaler_clear |-> $past(dec.writes_file && dec.file_addr == timer_addr && ctrl[1]))
        else $error("prescaler cleared without timer write");
    stable_in_cycle_a: assert property (@(posedge clk) disable iff (rst)
        (ce && phase != 2'h3) |=> $stable(dec))
        else $error("decode changed mid-cycle");
    literal_to_acc_a: assert property (@(posedge clk) disable iff (rst)
        (dec.op == OP_ADD_LIT || dec.op == OP_SUB_LIT) |->
        (!dec.dest_file && dec.upd_carry && dec.upd_digit_carry && dec.upd_zero))
        else $error("literal arithmetic controls wrong");
endmodule : instr_decoder

//--- rtl/instr_decoder_defines.svh
/*
 * Constants for the 14-bit instruction decoder: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the bench and the decoder.
 */
`ifndef INSTR_DECODER_DEFINES_SVH
`define INSTR_DECODER_DEFINES_SVH

// timing
`define CLK_PERIOD_NS      10
`define PHASES_PER_CYCLE   4

// register byte offsets on the bus
`define REG_CTRL           8'h00
`define REG_TIMER_ADDR     8'h04
`define REG_PORT_RANGE     8'h08
`define REG_STATUS         8'h0C
`define REG_LAST_WORD      8'h10

// control register fields
`define CTRL_RUN_BIT       0
`define CTRL_PRESC_T0_BIT  1
`define CTRL_RESET         32'h0000_0001

// reset values of the address registers
`define TIMER_ADDR_RESET   7'h01
`define PORT_LO_RESET      7'h05
`define PORT_HI_RESET      7'h09

// instruction word fields
`define WORD_MSB           13
`define FILE_MSB           6
`define DEST_BIT           7
`define BIT_IDX_LSB        7
`define UPPER_PC_LO        3

`endif

//--- rtl/instr_decoder_pkg.sv
/*
 * Types for the 14-bit instruction decoder: operation enumeration and the
 * decoded-control carrier handed to the datapath.
 * Assumes instr_decoder_defines.svh is on the include path.
 */
package instr_decoder_pkg;
    typedef enum logic [5:0] {
        OP_NOP, OP_STORE_ACC, OP_CLR_ACC, OP_CLR_FILE, OP_SUB_FILE, OP_DEC,
        OP_IOR_FILE, OP_AND_FILE, OP_XOR_FILE, OP_ADD_FILE, OP_MOVE_FILE,
        OP_COMP, OP_INC, OP_DEC_SKIPZ, OP_ROT_RIGHT, OP_ROT_LEFT, OP_SWAP,
        OP_INC_SKIPZ, OP_BIT_CLR, OP_BIT_SET, OP_SKIP_IF_CLR, OP_SKIP_IF_SET,
        OP_CALL, OP_JUMP, OP_LOAD_LIT, OP_RET_LIT, OP_IOR_LIT, OP_AND_LIT,
        OP_XOR_LIT, OP_SUB_LIT, OP_ADD_LIT, OP_CLR_WATCHDOG, OP_STANDBY,
        OP_RET_INT, OP_RET_SUB
    } op_e;

    typedef struct packed {
        op_e         op;
        logic        dest_file;   // result goes to file register
        logic [6:0]  file_addr;
        logic [2:0]  bit_idx;
        logic [7:0]  literal;
        logic [10:0] target;
        logic        upd_carry;
        logic        upd_digit_carry;
        logic        upd_zero;
        logic        upd_wdt_flags; // timeout_flag / powerdown_flag
        logic        writes_file;
        logic        changes_pc;
    } decode_s;
endpackage : instr_decoder_pkg
